// ==== hdl/thermal_agent_config_regs.v ====
// Configuration register bank for the thermal-link host: enables, bases,
// domain steering and link control, plus per-agent result selection.
// Assumes a same-clock register port with read data one cycle later;
// domain readings arrive from the link engine on the same clock.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "thermal_agent_regs.vh"
module thermal_agent_config_regs (
    input wire core_clk_i, // 200 MHz system clock
    input wire arst_n_i, // Async reset, active low
    input wire [7:0] reg_addr_i, // Register byte offset
    input wire [7:0] reg_wdata_i, // Write data
    input wire reg_wr_i, // Write strobe
    input wire reg_rd_i, // Read strobe
    output reg [7:0] reg_rdata_o, // Read data, cycle after strobe
    input wire [3:0] result_valid_i, // Link engine has new readings, per agent
    input wire [63:0] dom0_temp_i, // Domain 0 readings, agent1 in low bits
    input wire [63:0] dom1_temp_i, // Domain 1 readings, agent1 in low bits
    output wire [3:0] agent_enable_o, // Agents allowed on the link
    output wire [27:0] temp_base_o, // Bases, agent1 in low 7 bits
    output wire enhanced_request_mode_en_o, // Enhanced request-pin mode
    output wire external_host_select_o, // Another device hosts the link
    output wire [63:0] agent_temp_o // Reported temperature per agent
);
    reg [7:0] agent_cfg_r;
    reg [7:0] link_ctrl_r;
    reg [27:0] base_r;
    reg [7:0] rdata_nxt;
    wire hit_cfg;
    wire hit_link;
    wire [3:0] hit_base;

    // Address compare used by the write paths; the read path decodes with a case
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign hit_cfg = hit(reg_addr_i, `TA_ADDR_AGENT_CFG);
    assign hit_link = hit(reg_addr_i, `TA_ADDR_LINK_CTRL);
    // Decoded once here so the generate loop indexes a plain vector
    assign hit_base = {hit(reg_addr_i, `TA_ADDR_BASE4), hit(reg_addr_i, `TA_ADDR_BASE3),
        hit(reg_addr_i, `TA_ADDR_BASE2), hit(reg_addr_i, `TA_ADDR_BASE1)};

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            agent_cfg_r <= `TA_RST_AGENT_CFG; // RQ11
            link_ctrl_r <= `TA_RST_LINK_CTRL; // RQ12
        end else if (reg_wr_i) begin
            if (hit_cfg) begin
                agent_cfg_r <= reg_wdata_i; // RQ1 RQ2
            end
            if (hit_link) begin
                link_ctrl_r <= reg_wdata_i & `TA_LINK_CTRL_MASK; // RQ6 RQ7 RQ10 RQ14
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `TA_AGENTS; g = g + 1) begin : g_agent
            always @(posedge core_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    base_r[g*7 +: 7] <= `TA_RST_BASE; // RQ5
                end else if (reg_wr_i && hit_base[g]) begin
                    base_r[g*7 +: 7] <= reg_wdata_i[6:0]; // RQ4 RQ14
                end
            end

            // Agent four honours its select bit without the domain 1 flag
            agent_domain_pick u_pick (
                .core_clk_i(core_clk_i),
                .arst_n_i(arst_n_i),
                .update_i(result_valid_i[g] & agent_cfg_r[`TA_ENABLE_LSB+g]), // RQ13
                .has_second_i(link_ctrl_r[`TA_PRESENT_LSB+g]), // RQ3
                .sel_second_i(agent_cfg_r[g]),
                .honor_sel_i(g == 3),
                .highest_i(link_ctrl_r[`TA_BIT_HIGHEST]), // RQ8 RQ9
                .dom0_i(dom0_temp_i[g*16 +: 16]),
                .dom1_i(dom1_temp_i[g*16 +: 16]),
                .temp_o(agent_temp_o[g*16 +: 16])
            );
        end
    endgenerate

    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr_i)
            `TA_ADDR_AGENT_CFG: rdata_nxt = agent_cfg_r;
            `TA_ADDR_BASE1: rdata_nxt = {1'b0, base_r[6:0]}; // RQ14
            `TA_ADDR_BASE2: rdata_nxt = {1'b0, base_r[13:7]};
            `TA_ADDR_BASE3: rdata_nxt = {1'b0, base_r[20:14]};
            `TA_ADDR_BASE4: rdata_nxt = {1'b0, base_r[27:21]};
            `TA_ADDR_LINK_CTRL: rdata_nxt = link_ctrl_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data holds only in the cycle after the strobe
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
        end
    end

    assign agent_enable_o = agent_cfg_r[7:4]; // RQ1 RQ13
    assign temp_base_o = base_r;
    assign enhanced_request_mode_en_o = link_ctrl_r[`TA_BIT_ENHANCED]; // RQ7
    assign external_host_select_o = link_ctrl_r[`TA_BIT_EXT_HOST]; // RQ10
endmodule // thermal_agent_config_regs
`default_nettype wire

// ==== hdl/thermal_agent_regs.vh ====
// Constants for the thermal agent configuration register bank.
// Assumes an 8-bit configuration port with byte offsets E0h..E5h.
// How it works
// RQ1: Bits 7..4 of agent config enable agents four..one, set enables.
// RQ2: Bits 3..0 pick reporting domain per agent, clear domain 0, set domain 1.
// RQ3: Agents one to three obey domain select only when second domain present.
// RQ4: Four base registers hold a 7-bit value in bits 6..0, bit 7 reserved.
// RQ5: Every base register resets to 48h.
// RQ6: Link control bits 7..4 flag a second domain for agents four..one.
// RQ7: Link control bit 3 selects enhanced request-pin transmission mode.
// RQ8: Link control bit 1 set reports the higher of both domains per agent.
// RQ9: Link control bit 1 clear lets per-agent domain select bits decide.
// RQ10: Link control bit 0 set hands the link to an external host.
// RQ11: Agent config resets to 00h: all agents off, all report domain 0.
// RQ12: Link control resets to 00h; its bit 2 is reserved.
// RQ13: Disabled agents get no transactions and their results stay untouched.
// RQ14: Reserved bits read zero and ignore writes.
`ifndef THERMAL_AGENT_REGS_VH
`define THERMAL_AGENT_REGS_VH

`define TA_ADDR_AGENT_CFG 8'he0
`define TA_ADDR_BASE1 8'he1
`define TA_ADDR_BASE2 8'he2
`define TA_ADDR_BASE3 8'he3
`define TA_ADDR_BASE4 8'he4
`define TA_ADDR_LINK_CTRL 8'he5

`define TA_RST_AGENT_CFG 8'h00
`define TA_RST_BASE 7'h48
`define TA_RST_LINK_CTRL 8'h00

`define TA_ENABLE_LSB 4
`define TA_PRESENT_LSB 4
`define TA_BIT_ENHANCED 3
`define TA_BIT_RESERVED 2
`define TA_BIT_HIGHEST 1
`define TA_BIT_EXT_HOST 0
`define TA_LINK_CTRL_MASK 8'hfb

`define TA_AGENTS 4
`define TA_TEMP_W 16

`endif

// ==== hdl/agent_domain_pick.v ====
// Per-agent choice of reported temperature from two domain readings.
// Assumes both readings are registered, same-clock data.
`timescale 1ns/100ps
`default_nettype none
module agent_domain_pick (
    input wire core_clk_i, // System clock
    input wire arst_n_i, // Async reset, active low
    input wire update_i, // Latch new result this cycle
    input wire has_second_i, // Agent has domain 1
    input wire sel_second_i, // Domain select bit
    input wire honor_sel_i, // Select works without domain 1 flag
    input wire highest_i, // Report higher of both domains
    input wire [15:0] dom0_i, // Domain 0 reading
    input wire [15:0] dom1_i, // Domain 1 reading
    output reg [15:0] temp_o // Reported temperature
);
    wire sel_ok;
    wire use_dom1;
    wire [15:0] hi_val;

    assign sel_ok = sel_second_i & (has_second_i | honor_sel_i); // RQ3
    // Signed compare: relative temperatures are negative offsets
    assign hi_val = ($signed(dom1_i) > $signed(dom0_i)) ? dom1_i : dom0_i;
    assign use_dom1 = sel_ok; // RQ9

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            temp_o <= 16'h0000;
        end else if (update_i) begin // RQ13
            if (highest_i) begin
                temp_o <= hi_val; // RQ8
            end else begin
                temp_o <= use_dom1 ? dom1_i : dom0_i; // RQ2
            end
        end
    end
endmodule // agent_domain_pick
`default_nettype wire

// ==== tb/thermal_agent_model.sv ====
// Behavioural processor agents answering a poll.
// Assumes the bench raises req_i for one cycle per poll.
`timescale 1ns/100ps
`default_nettype none
module thermal_agent_model (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic [3:0] req_i, // Poll
    input wire logic [127:0] temps_i, // Readings, dom1 on top
    output logic [3:0] valid_o, // Answer flag
    output logic [127:0] temps_o // Readings
);
    logic [127:0] last_r;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_o <= 4'h0;
            last_r <= 128'h0;
        end else begin
            valid_o <= req_i;
            if (|req_i)
                last_r <= temps_i;
        end
    end
    // Idle lines must not hold the old answer
    assign temps_o = |valid_o ? last_r : ~last_r;
endmodule // thermal_agent_model
`default_nettype wire

// ==== tb/cfg_regs_properties.sv ====
// Checker bound to the register bank top.
// Assumes one clock and async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cfg_checker (
    input wire logic core_clk_i, // Clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_addr_i, // Register offset
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic [3:0] result_valid_i, // New readings per agent
    input wire logic [3:0] agent_enable_o, // Agent enables
    input wire logic [27:0] temp_base_o, // Bases
    input wire logic external_host_select_o, // External host
    input wire logic [63:0] agent_temp_o // Reported temperatures
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic w0 = reg_wr_i && reg_addr_i == 8'he0;
    a_en_write: assert property (w0 |=> agent_enable_o == $past(reg_wdata_i[7:4]))
        else $error("enable");
    a_en_hold: assert property (!w0 |=> $stable(agent_enable_o))
        else $error("enable hold");
    a_en_read: assert property (reg_rd_i && reg_addr_i == 8'he0
        |=> reg_rdata_o[7:4] == $past(agent_enable_o)) else $error("enable read");
    a_base_write: assert property (reg_wr_i && reg_addr_i == 8'he1
        |=> temp_base_o[6:0] == $past(reg_wdata_i[6:0])) else $error("base");
    a_host_write: assert property (reg_wr_i && reg_addr_i == 8'he5
        |=> external_host_select_o == $past(reg_wdata_i[0])) else $error("host");
    a_base_rsvd: assert property (reg_rd_i && reg_addr_i == 8'he3 |=> !reg_rdata_o[7])
        else $error("base bit 7");
    a_link_rsvd: assert property (reg_rd_i && reg_addr_i == 8'he5 |=> !reg_rdata_o[2])
        else $error("link bit 2");
    a_unmapped_read: assert property (reg_rd_i && reg_addr_i > 8'he5
        |=> reg_rdata_o == 8'h00) else $error("unmapped read");
    a_off_hold: assert property (result_valid_i[1] && !agent_enable_o[1]
        |=> $stable(agent_temp_o[31:16])) else $error("disabled agent");
    cover property (w0);
    cover property (result_valid_i[0] && agent_enable_o[0]);
    cover property (reg_rd_i && reg_addr_i == 8'he5);
    cover property (reg_rd_i && reg_addr_i == 8'he6);
endmodule // cfg_checker
bind thermal_agent_config_regs cfg_checker i_chk (.core_clk_i, .arst_n_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .result_valid_i, .agent_enable_o,
    .temp_base_o, .external_host_select_o, .agent_temp_o);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the register bank.
// Assumes the agent model and checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, enh, ext;
    logic [7:0] addr = 0, wd = 0, rdata, mem [8];
    logic [3:0] req = 0, vld, en;
    logic [127:0] tin = 0, tout;
    logic [63:0] at, et = 0;
    logic [27:0] base;
    int n_mismatch = 0, check_count = 0;
    always #2.5 clk = ~clk;
    thermal_agent_model i_agents (.clk_i(clk), .arst_n_i(rst_n), .req_i(req),
        .temps_i(tin), .valid_o(vld), .temps_o(tout));
    thermal_agent_config_regs i_dut (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .result_valid_i(vld), .dom0_temp_i(tout[63:0]), .dom1_temp_i(tout[127:64]),
        .agent_enable_o(en), .temp_base_o(base), .enhanced_request_mode_en_o(enh),
        .external_host_select_o(ext), .agent_temp_o(at));
    task automatic chk(input logic [63:0] s, e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Reserved bits drop, unmapped offsets keep nothing
    function automatic logic [7:0] keep(input int i, input logic [7:0] d);
        return i == 0 ? d : i == 5 ? d & 8'hfb : i < 5 ? d & 8'h7f : 8'h00;
    endfunction
    function automatic logic [15:0] pick(input int n, input logic [15:0] d0, d1);
        if (mem[5][1])
            return $signed(d1) > $signed(d0) ? d1 : d0;
        return mem[0][n] && (mem[5][n + 4] || n == 3) ? d1 : d0;
    endfunction
    initial begin
        // Tests need under a thousand cycles; ten times that is a hang
        #50000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        int a;
        logic [7:0] v;
        void'($urandom(32'hb565017f));
        for (int i = 0; i < 8; i++)
            mem[i] = (i > 0 && i < 5) ? 8'h48 : 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        for (int r = 0; r < 40; r++) begin
            // Reset in mid-run must bring back every default
            if (r == 20) begin
                @(posedge clk);
                rst_n <= 0;
                @(posedge clk);
                rst_n <= 1;
                et = 0;
                for (int i = 0; i < 8; i++)
                    mem[i] = (i > 0 && i < 5) ? 8'h48 : 8'h00;
            end
            for (int i = 0; i < 7; i++) begin
                @(posedge clk);
                rd <= 1;
                addr <= 8'(8'he0 + i);
                @(posedge clk);
                rd <= 0;
                #1 chk(64'(rdata), 64'(mem[i]));
            end
            // First round: all enabled, no second domains, only agent 4 select counts
            a = r == 0 ? 0 : r == 1 ? 5 : $urandom_range(6);
            v = r < 2 ? 8'hff * (r == 0) : 8'($urandom);
            @(posedge clk);
            wr <= 1;
            addr <= 8'(8'he0 + a);
            wd <= v;
            mem[a] = keep(a, v);
            @(posedge clk);
            wr <= 0;
            tin <= {$urandom, $urandom, $urandom, $urandom};
            req <= 4'($urandom);
            #1 chk({en, base, enh, ext}, {mem[0][7:4], mem[4][6:0], mem[3][6:0],
                mem[2][6:0], mem[1][6:0], mem[5][3], mem[5][0]});
            @(posedge clk);
            for (int n = 0; n < 4; n++)
                if (req[n] && mem[0][n + 4])
                    et[16 * n +: 16] = pick(n, tin[16 * n +: 16], tin[64 + 16 * n +: 16]);
            req <= 0;
            repeat (2) @(posedge clk);
            #1 chk(at, et);
        end
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
